/* acrb_defs.vh */
// Constants of the accelerometer register bank
`ifndef ACRB_DEFS_VH
`define ACRB_DEFS_VH
`define ACRB_A_IDENT 8'h00
`define ACRB_A_FAULT 8'h02
`define ACRB_A_STATUS 8'h03
`define ACRB_A_XL 8'h12
`define ACRB_A_XH 8'h13
`define ACRB_A_YL 8'h14
`define ACRB_A_YH 8'h15
`define ACRB_A_ZL 8'h16
`define ACRB_A_ZH 8'h17
`define ACRB_A_T0 8'h18
`define ACRB_A_T1 8'h19
`define ACRB_A_T2 8'h1a
`define ACRB_A_IRQF 8'h1d
`define ACRB_A_TMPH 8'h22
`define ACRB_A_TMPL 8'h23
`define ACRB_A_CONF 8'h40
`define ACRB_A_RANGE 8'h41
`define ACRB_A_IO1 8'h53
`define ACRB_A_IO2 8'h54
`define ACRB_A_MAP 8'h58
`define ACRB_A_STEST 8'h6d
`define ACRB_A_PSAVE 8'h7c
`define ACRB_A_PEN 8'h7d
`define ACRB_A_RST 8'h7e
`define ACRB_RST_CONF 8'ha8
`define ACRB_RST_RANGE 8'h01
`define ACRB_RST_PSAVE 8'h03
`define ACRB_RST_ZERO 8'h00
`define ACRB_STATUS_FIXED 8'h10
`define ACRB_RESET_CODE 8'hb6
`define ACRB_ERR_NONE 3'h0
`define ACRB_ERR_CONF 3'h1
`define ACRB_CONF_ODR_MIN 4'h5
`define ACRB_CONF_ODR_MAX 4'hc
`define ACRB_CONF_BWP_MAX 3'h2
`define ACRB_RESET_DELAY_NS 1000
`define ACRB_CLK_NS 10
`endif

/* acrb_axis_latch.v */
// One axis sample with low-byte-read freeze of the high byte
`timescale 1ns/10ps
module acrb_axis_latch #(
  parameter W = 16
) (
  clk,
  rst,
  load,
  sample,
  lo_read,
  hi_read,
  lo_byte,
  hi_byte
);
  input wire clk;
  input wire rst;
  input wire load;
  input wire [W-1:0] sample;
  input wire lo_read;
  input wire hi_read;
  output wire [7:0] lo_byte;
  output wire [7:0] hi_byte;

  reg [W-1:0] val_q;
  reg [7:0] hi_hold_q;
  reg frozen_q;

  assign lo_byte = val_q[7:0];
  assign hi_byte = frozen_q ? hi_hold_q : val_q[15:8];

  always @(posedge clk)
  begin
    if (rst)
    begin
      val_q <= {W{1'b0}};
      hi_hold_q <= 8'h00;
      frozen_q <= 1'b0;
    end
    else
    begin
      if (load)
        val_q <= sample;
      if (lo_read)
      begin
        frozen_q <= 1'b1;
        hi_hold_q <= val_q[15:8];
      end
      else if (hi_read)
        frozen_q <= 1'b0;
    end
  end
endmodule

/* acrb_bank.v */
// Accelerometer register bank top
//
// Behaviour
// - Address 0x00 reads a fixed identity code; writes are ignored.
// - Fault code in bits 4:2; 1 means sampling config holds invalid setting.
// - Fatal flag bit 0 set when the boot_fail input is asserted.
// - Fatal flag cleared only by power-on reset or soft-reset.
// - Status bit 7 set on new sample, cleared by any axis register read.
// - Writing reset code to reset_command resets the bank after a delay.
// - Reading an axis low byte freezes its high byte until read.
// - Interrupt flags bit 7 cleared when that register is read.
// - All registers eight bits wide in an eight-bit address space.
`timescale 1ns/10ps
`include "acrb_defs.vh"
module acrb_bank #(
  // Identity code value is arbitrary
  parameter [7:0] IDENTITY_VALUE = 8'h5a,
  parameter RESET_DELAY_CYC = (`ACRB_RESET_DELAY_NS + `ACRB_CLK_NS - 1) / `ACRB_CLK_NS
) (
  clk,
  rst,
  sel,
  wr,
  rd,
  addr,
  wdata,
  rdata,
  rvalid,
  sample_valid,
  sample_x,
  sample_y,
  sample_z,
  sample_time,
  sample_temp,
  boot_fail,
  sampling_config,
  full_scale_select,
  irq_pin_one_setup,
  irq_pin_two_setup,
  irq_routing,
  selftest_control,
  power_save_config,
  power_enable,
  soft_reset_busy
);
  input wire clk;
  input wire rst;
  input wire sel;
  input wire wr;
  input wire rd;
  input wire [7:0] addr;
  input wire [7:0] wdata;
  output reg [7:0] rdata;
  output reg rvalid;
  input wire sample_valid;
  input wire [15:0] sample_x;
  input wire [15:0] sample_y;
  input wire [15:0] sample_z;
  input wire [23:0] sample_time;
  input wire [10:0] sample_temp;
  input wire boot_fail;
  output reg [7:0] sampling_config;
  output reg [7:0] full_scale_select;
  output reg [7:0] irq_pin_one_setup;
  output reg [7:0] irq_pin_two_setup;
  output reg [7:0] irq_routing;
  output reg [7:0] selftest_control;
  output reg [7:0] power_save_config;
  output reg [7:0] power_enable;
  output reg soft_reset_busy;

  // ****************************************
  // Soft reset sequencing
  // ****************************************
  localparam ST_RUN = 1'b0;
  localparam ST_WAIT = 1'b1;
  localparam CW = 16;

  reg state_q;
  reg [CW-1:0] cnt_q;
  reg soft_rst_q;
  wire rd_acc;
  wire wr_acc;
  wire bank_rst;

  assign rd_acc = sel & rd;
  assign wr_acc = sel & wr;
  assign bank_rst = rst | soft_rst_q;

  always @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= ST_RUN;
      cnt_q <= {CW{1'b0}};
      soft_rst_q <= 1'b0;
      soft_reset_busy <= 1'b0;
    end
    else
    begin
      soft_rst_q <= 1'b0;
      // Busy falls with the edge that applies the defaults, so no write is lost
      if (soft_rst_q)
        soft_reset_busy <= 1'b0;
      case (state_q)
        ST_RUN:
        begin
          if (wr_acc && addr == `ACRB_A_RST && wdata == `ACRB_RESET_CODE)
          begin
            state_q <= ST_WAIT;
            cnt_q <= RESET_DELAY_CYC[CW-1:0];
            soft_reset_busy <= 1'b1;
          end
        end
        ST_WAIT:
        begin
          if (cnt_q <= {{(CW-1){1'b0}}, 1'b1})
          begin
            soft_rst_q <= 1'b1;
            state_q <= ST_RUN;
            cnt_q <= {CW{1'b0}};
          end
          else
            cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
        end
        default:
        begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  // ****************************************
  // Input synchronisers
  // ****************************************
  reg boot_m_q;
  reg boot_s_q;
  reg sv_m_q;
  reg sv_s_q;
  reg sv_d_q;
  wire new_sample;

  always @(posedge clk)
  begin
    if (rst)
    begin
      boot_m_q <= 1'b0;
      boot_s_q <= 1'b0;
      sv_m_q <= 1'b0;
      sv_s_q <= 1'b0;
      sv_d_q <= 1'b0;
    end
    else
    begin
      boot_m_q <= boot_fail;
      boot_s_q <= boot_m_q;
      sv_m_q <= sample_valid;
      sv_s_q <= sv_m_q;
      sv_d_q <= sv_s_q;
    end
  end

  assign new_sample = sv_s_q & ~sv_d_q;

  // ****************************************
  // Sample data
  // ****************************************
  wire [7:0] xl;
  wire [7:0] xh;
  wire [7:0] yl;
  wire [7:0] yh;
  wire [7:0] zl;
  wire [7:0] zh;
  reg [23:0] time_q;
  reg [10:0] temp_q;

  acrb_axis_latch #(.W(16)) u_x (
    .clk(clk),
    .rst(bank_rst),
    .load(new_sample),
    .sample(sample_x),
    .lo_read(rd_acc && addr == `ACRB_A_XL),
    .hi_read(rd_acc && addr == `ACRB_A_XH),
    .lo_byte(xl),
    .hi_byte(xh)
  );

  acrb_axis_latch #(.W(16)) u_y (
    .clk(clk),
    .rst(bank_rst),
    .load(new_sample),
    .sample(sample_y),
    .lo_read(rd_acc && addr == `ACRB_A_YL),
    .hi_read(rd_acc && addr == `ACRB_A_YH),
    .lo_byte(yl),
    .hi_byte(yh)
  );

  acrb_axis_latch #(.W(16)) u_z (
    .clk(clk),
    .rst(bank_rst),
    .load(new_sample),
    .sample(sample_z),
    .lo_read(rd_acc && addr == `ACRB_A_ZL),
    .hi_read(rd_acc && addr == `ACRB_A_ZH),
    .lo_byte(zl),
    .hi_byte(zh)
  );

  always @(posedge clk)
  begin
    if (bank_rst)
    begin
      time_q <= 24'h000000;
      temp_q <= 11'h000;
    end
    else if (new_sample)
    begin
      time_q <= sample_time;
      temp_q <= sample_temp;
    end
  end

  // ****************************************
  // Flags
  // ****************************************
  reg drdy_q;
  reg irq_drdy_q;
  reg fatal_q;
  wire axis_rd;
  wire conf_bad;

  assign axis_rd = rd_acc && addr >= `ACRB_A_XL && addr <= `ACRB_A_ZH;
  assign conf_bad = ~sampling_config[7] || sampling_config[6:4] > `ACRB_CONF_BWP_MAX ||
    sampling_config[3:0] < `ACRB_CONF_ODR_MIN || sampling_config[3:0] > `ACRB_CONF_ODR_MAX;

  always @(posedge clk)
  begin
    if (bank_rst)
    begin
      drdy_q <= 1'b0;
      irq_drdy_q <= 1'b0;
      fatal_q <= 1'b0;
    end
    else
    begin
      if (new_sample)
        drdy_q <= 1'b1;
      else if (axis_rd)
        drdy_q <= 1'b0;
      if (new_sample)
        irq_drdy_q <= 1'b1;
      else if (rd_acc && addr == `ACRB_A_IRQF)
        irq_drdy_q <= 1'b0;
      if (boot_s_q)
        fatal_q <= 1'b1;
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always @(posedge clk)
  begin
    if (bank_rst)
    begin
      sampling_config <= `ACRB_RST_CONF;
      full_scale_select <= `ACRB_RST_RANGE;
      irq_pin_one_setup <= `ACRB_RST_ZERO;
      irq_pin_two_setup <= `ACRB_RST_ZERO;
      irq_routing <= `ACRB_RST_ZERO;
      selftest_control <= `ACRB_RST_ZERO;
      power_save_config <= `ACRB_RST_PSAVE;
      power_enable <= `ACRB_RST_ZERO;
    end
    else if (wr_acc)
    begin
      // read-only and reserved writes fall through
      case (addr)
        `ACRB_A_CONF: sampling_config <= wdata;
        `ACRB_A_RANGE: full_scale_select <= wdata;
        `ACRB_A_IO1: irq_pin_one_setup <= wdata;
        `ACRB_A_IO2: irq_pin_two_setup <= wdata;
        `ACRB_A_MAP: irq_routing <= wdata;
        `ACRB_A_STEST: selftest_control <= wdata;
        `ACRB_A_PSAVE: power_save_config <= wdata;
        `ACRB_A_PEN: power_enable <= wdata;
        default: sampling_config <= sampling_config;
      endcase
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  reg [7:0] rd_d;

  always @*
  begin
    rd_d = 8'h00;
    case (addr)
      `ACRB_A_IDENT: rd_d = IDENTITY_VALUE;
      `ACRB_A_FAULT: rd_d = {3'h0, conf_bad ? `ACRB_ERR_CONF : `ACRB_ERR_NONE, 1'b0, fatal_q};
      `ACRB_A_STATUS: rd_d = `ACRB_STATUS_FIXED | {drdy_q, 7'h00};
      `ACRB_A_XL: rd_d = xl;
      `ACRB_A_XH: rd_d = xh;
      `ACRB_A_YL: rd_d = yl;
      `ACRB_A_YH: rd_d = yh;
      `ACRB_A_ZL: rd_d = zl;
      `ACRB_A_ZH: rd_d = zh;
      `ACRB_A_T0: rd_d = time_q[7:0];
      `ACRB_A_T1: rd_d = time_q[15:8];
      `ACRB_A_T2: rd_d = time_q[23:16];
      `ACRB_A_IRQF: rd_d = {irq_drdy_q, 7'h00};
      `ACRB_A_TMPH: rd_d = temp_q[10:3];
      `ACRB_A_TMPL: rd_d = {temp_q[2:0], 5'h00};
      `ACRB_A_CONF: rd_d = sampling_config;
      `ACRB_A_RANGE: rd_d = full_scale_select;
      `ACRB_A_IO1: rd_d = irq_pin_one_setup;
      `ACRB_A_IO2: rd_d = irq_pin_two_setup;
      `ACRB_A_MAP: rd_d = irq_routing;
      `ACRB_A_STEST: rd_d = selftest_control;
      `ACRB_A_PSAVE: rd_d = power_save_config;
      `ACRB_A_PEN: rd_d = power_enable;
      default: rd_d = 8'h00;
    endcase
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end
    else
    begin
      rvalid <= rd_acc;
      if (rd_acc)
        rdata <= rd_d;
    end
  end
endmodule

/* acrb_host.sv */
// Host model that issues register reads and writes
`timescale 1ns/10ps
module acrb_host (
  input wire logic clk,
  output logic sel,
  output logic wr,
  output logic rd,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  initial
  begin
    {sel, wr, rd, addr, wdata} = 19'h0;
  end
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge clk);
    {sel, wr, rd, addr, wdata} = {1'b1, w, !w, a, d};
    @(negedge clk);
    q = (w || rvalid) ? rdata : 8'hxx;
    {sel, wr, rd, addr, wdata} = {3'h0, ~addr, ~wdata};
  endtask
endmodule

/* acrb_bank_properties.sv */
// Concurrent checks on the register bank ports
`timescale 1ns/10ps
module acrb_bank_props #(
  parameter [7:0] IDENTITY_VALUE = 8'h5a,
  parameter RESET_DELAY_CYC = 2
) (
  input wire clk,
  input wire rst,
  input wire sel,
  input wire wr,
  input wire rd,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire [7:0] rdata,
  input wire rvalid,
  input wire [7:0] sampling_config,
  input wire soft_reset_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire rq = sel && rd;
  chk_read_answer: assert property (rq |=> rvalid)
    else $error("read not answered");
  chk_no_spur: assert property (rvalid |-> $past(rq))
    else $error("rvalid without read");
  chk_ident_val: assert property (rq && addr == 8'h00 |=> rdata == IDENTITY_VALUE)
    else $error("identity wrong");
  chk_fault_rsv: assert property (rq && addr == 8'h02 |=> rdata[7:5] == 3'h0 && !rdata[1])
    else $error("fault reserved bits set");
  chk_status_fix: assert property (rq && addr == 8'h03 |=> rdata[6:0] == 7'h10)
    else $error("status low bits wrong");
  chk_rsv_zero: assert property (rq && (addr == 8'h01 || addr == 8'h05) |=> rdata == 8'h00)
    else $error("reserved read not zero");
  chk_conf_write: assert property (sel && wr && addr == 8'h40 && !soft_reset_busy
    |=> sampling_config == $past(wdata))
    else $error("config write lost");
  chk_reset_start: assert property (sel && wr && addr == 8'h7e && wdata == 8'hb6
    |=> soft_reset_busy)
    else $error("soft reset not started");
  chk_reset_ends: assert property ($rose(soft_reset_busy) |-> ##[1:1000] !soft_reset_busy)
    else $error("soft reset never ends");
  chk_reset_dflt: assert property ($fell(soft_reset_busy) |-> sampling_config == 8'ha8)
    else $error("config not defaulted");
  cover property (sel && wr && addr == 8'h7e && wdata == 8'hb6);
  cover property (rq && addr == 8'h13);
  cover property ($fell(soft_reset_busy));
endmodule
bind acrb_bank acrb_bank_props #(.IDENTITY_VALUE(IDENTITY_VALUE),
  .RESET_DELAY_CYC(RESET_DELAY_CYC)) acrb_bank_props_i (.clk(clk), .rst(rst), .sel(sel),
  .wr(wr), .rd(rd), .addr(addr), .wdata(wdata), .rdata(rdata), .rvalid(rvalid),
  .sampling_config(sampling_config), .soft_reset_busy(soft_reset_busy));

/* testbench.sv */
// Self-checking bench for the accelerometer register bank
`timescale 1ns/10ps
module testbench;
  // Identity code value is arbitrary
  localparam [7:0] IDV = 8'h3c;
  logic clk, rst, sv, bf;
  logic [15:0] ax [3];
  logic [15:0] old [3];
  logic [23:0] st;
  logic [10:0] tp;
  logic [7:0] q;
  wire sel, wr, rd, rvalid, busy;
  wire [7:0] addr, wdata, rdata;
  wire [7:0] co [8];
  int n_errors, check_count, i, k, cyc;
  int seed = 32'h15102030;
  int ca [8] = '{8'h40, 8'h41, 8'h53, 8'h54, 8'h58, 8'h6d, 8'h7c, 8'h7d};
  int dv [8] = '{8'ha8, 8'h01, 0, 0, 0, 0, 8'h03, 0};
  int ev [8];
  acrb_host acrb_host_i (.clk(clk), .sel(sel), .wr(wr), .rd(rd), .addr(addr),
    .wdata(wdata), .rdata(rdata), .rvalid(rvalid));
  acrb_bank #(.IDENTITY_VALUE(IDV), .RESET_DELAY_CYC(2)) acrb_bank_i (.clk(clk), .rst(rst),
    .sel(sel), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata), .rdata(rdata), .rvalid(rvalid),
    .sample_valid(sv), .sample_x(ax[0]), .sample_y(ax[1]), .sample_z(ax[2]),
    .sample_time(st), .sample_temp(tp), .boot_fail(bf), .sampling_config(co[0]),
    .full_scale_select(co[1]), .irq_pin_one_setup(co[2]), .irq_pin_two_setup(co[3]),
    .irq_routing(co[4]), .selftest_control(co[5]), .power_save_config(co[6]),
    .power_enable(co[7]), .soft_reset_busy(busy));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task summarize;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      summarize;
    end
  end
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task rr(input logic [7:0] a, input logic [7:0] e, input string n);
    acrb_host_i.xfer(1'b0, a, 8'h00, q);
    chk(n, e, q);
  endtask
  task ww(input logic [7:0] a, input logic [7:0] d);
    acrb_host_i.xfer(1'b1, a, d, q);
  endtask
  // New sample on a rising edge of the valid level
  task smp;
    @(negedge clk);
    for (k = 0; k < 3; k++)
      ax[k] = 16'($random(seed));
    {st, tp} = 35'($random(seed));
    sv = 1'b1;
    repeat (8) @(negedge clk);
    sv = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  initial
  begin
    {rst, sv, bf, st, tp} = 38'h2000000000;
    for (i = 0; i < 3; i++)
      ax[i] = 16'h0;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    rr(8'h00, IDV, "ident");
    ww(8'h00, 8'h33);
    rr(8'h00, IDV, "ident_wr");
    rr(8'h02, 8'h00, "fault");
    rr(8'h03, 8'h10, "status");
    ww(8'h05, 8'hff);
    rr(8'h05, 8'h00, "rsv");
    for (i = 0; i < 8; i++)
    begin
      rr(8'(ca[i]), 8'(dv[i]), "cfg_rst");
      ev[i] = $random(seed) & 8'hff;
      ww(8'(ca[i]), 8'(ev[i]));
      rr(8'(ca[i]), 8'(ev[i]), "cfg_rd");
      chk("cfg_port", 8'(ev[i]), co[i]);
    end
    ww(8'h40, 8'h28);
    rr(8'h02, 8'h04, "fault_cfg");
    ww(8'h40, 8'ha8);
    rr(8'h02, 8'h00, "fault_ok");
    smp;
    rr(8'h03, 8'h90, "drdy");
    rr(8'h1d, 8'h80, "irqf");
    rr(8'h1d, 8'h00, "irqf_clr");
    for (i = 0; i < 3; i++)
      rr(8'(8'h12 + 2 * i), ax[i][7:0], "lo");
    rr(8'h03, 8'h10, "drdy_clr");
    old = ax;
    smp;
    for (i = 0; i < 3; i++)
      rr(8'(8'h13 + 2 * i), old[i][15:8], "hi_frozen");
    for (i = 0; i < 3; i++)
      rr(8'(8'h13 + 2 * i), ax[i][15:8], "hi_live");
    rr(8'h18, st[7:0], "time0");
    rr(8'h19, st[15:8], "time1");
    rr(8'h1a, st[23:16], "time2");
    rr(8'h22, tp[10:3], "temp_hi");
    rr(8'h23, {tp[2:0], 5'h00}, "temp_lo");
    @(negedge clk);
    bf = 1'b1;
    repeat (4) @(negedge clk);
    bf = 1'b0;
    rr(8'h02, 8'h01, "fatal");
    ww(8'h7e, 8'h5a);
    rr(8'h02, 8'h01, "fatal_hold");
    // Non-default config so the soft reset has something to restore
    ww(8'h40, 8'h28);
    rr(8'h02, 8'h05, "fault_both");
    ww(8'h7e, 8'hb6);
    k = 0;
    while (busy !== 1'b0 && k < 200)
    begin
      @(negedge clk);
      k++;
    end
    rr(8'h02, 8'h00, "fatal_clr");
    rr(8'h12, 8'h00, "axis_dflt");
    rr(8'h18, 8'h00, "time_dflt");
    rr(8'h03, 8'h10, "status_dflt");
    for (i = 0; i < 8; i++)
      chk("cfg_dflt", 8'(dv[i]), co[i]);
    summarize;
  end
endmodule
